// ---- bench/hprs_host_model.sv ----
// hprs_host_model: external host driving the strobe/ready handshake.
// assumes it shares pclk with the port and is called one cycle at a time.
`timescale 1ns/1ps
`default_nettype none
module hprs_host_model (
	// clock
	input wire logic pclk,
	// host side
	output var hprs_pkg::hprs_host_pins_t pins,
	input wire logic host_ready,
	input wire logic [15:0] host_rdata
);
	import hprs_pkg::*;
	initial pins = '{strobe_n: 1'b1, rnw: 1'b1, sel: 2'h0, wdata: 16'hffff};
	// one host cycle; ok stays low when ready never came within lim
	task automatic xfer(input logic rnw, input logic [1:0] sel, input logic [15:0] wd, input int lim,
		output logic [15:0] rd, output logic ok);
		int n;
		n = 0;
		@(posedge pclk);
		pins <= '{strobe_n: 1'b0, rnw: rnw, sel: sel, wdata: wd};
		@(negedge pclk);
		while (host_ready !== 1'b1 && n < lim) begin
			@(negedge pclk);
			n++;
		end
		ok = (host_ready === 1'b1);
		@(posedge pclk);
		@(negedge pclk);
		rd = host_rdata;
		@(posedge pclk);
		// released lines show no stale value; strobe idles 3 cycles
		pins <= '{strobe_n: 1'b1, rnw: ~rnw, sel: ~sel, wdata: ~wd};
		repeat (3) @(posedge pclk);
	endtask : xfer
endmodule : hprs_host_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// tb_top: self-checking bench for the host port reset/suspend block.
// assumes hprs_host_model as host; memory side is modelled here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import hprs_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} hprs_row_t;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, host_ready, dma_ack = 1'b0, emu_suspend = 1'b0, idle_req = 1'b0;
	logic idle_ack, cpu_int, host_int, ok, er;
	logic [15:0] host_rdata, dma_rdata = 16'h0, last_a, last_w, hd;
	logic [7:0] gpio_out, gpio_oe_n;
	hprs_host_pins_t host_pins;
	hprs_dma_req_t dma_out;
	int num_errors = 0, samples_checked = 0, n_dma = 0, cyc = 0, n0;
	logic [1:0] modes[4] = '{2'h1, 2'h0, 2'h3, 2'h2};
	hprs_row_t rows[13] = '{'{1'b0, 8'h04, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
		'{1'b0, 8'h0c, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0},
		'{1'b1, 8'h04, 32'h1234, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h1234, 1'b0},
		'{1'b1, 8'h08, 32'h0200, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0200, 1'b0},
		'{1'b1, 8'h0c, 32'hf0ff0f, 32'h0, 1'b0}, '{1'b0, 8'h0c, 32'h0, 32'hf0ff0f, 1'b0},
		'{1'b0, 8'h10, 32'h0, 32'h5a, 1'b0}, '{1'b1, 8'h20, 32'h1, 32'h0, 1'b1},
		'{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}};
	always #5 pclk = ~pclk;
	hprs_top u_hprs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_pins(host_pins), .host_rdata(host_rdata), .host_ready(host_ready), .dma_out(dma_out),
		.dma_ack(dma_ack), .dma_rdata(dma_rdata), .emu_suspend(emu_suspend), .idle_req(idle_req),
		.idle_ack(idle_ack), .cpu_int(cpu_int), .host_int(host_int), .gpio_in(8'h5a),
		.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
	hprs_host_model u_hprs_host_model (.pclk(pclk), .pins(host_pins), .host_ready(host_ready),
		.host_rdata(host_rdata));
	// memory acks each request one cycle after seeing it
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		dma_ack <= 1'b0;
		if (dma_out.req === 1'b1 && !dma_ack) begin
			dma_ack <= 1'b1;
			dma_rdata <= ~dma_out.addr;
			n_dma <= n_dma + 1;
			last_a <= dma_out.addr;
			last_w <= dma_out.wdata;
		end
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic hwr(input logic [15:0] wd, input int lim);
		u_hprs_host_model.xfer(1'b0, HPRS_HSEL_DATA, wd, lim, hd, ok);
	endtask : hwr
	task automatic complete_run();
		if (num_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(negedge pclk);
		chk("stretch ready", host_ready, 0);
		repeat (20) @(posedge pclk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk("apb read", rd, rows[i].r);
			chk("apb error", er, rows[i].e);
		end
		chk("gpio oe", gpio_oe_n, 8'hf0);
		chk("gpio out", gpio_out, 8'hf0);
		foreach (modes[i]) begin
			apb(1'b1, HPRS_OFF_EMU, {30'h0, modes[i]});
			emu_suspend <= 1'b1;
			n0 = n_dma;
			hwr(16'h1000 + 16'(i), 40);
			repeat (10) @(posedge pclk);
			chk("dma moves", n_dma - n0, modes[i] != 2'h2);
		end
		for (int i = 1; i < 8; i++) hwr(16'h2000 + 16'(i), 40);
		chk("fill ok", ok, 1);
		fork
			hwr(16'h2008, 400);
			begin
				repeat (30) @(negedge pclk);
				chk("blocked ready", host_ready, 0);
				@(posedge pclk);
				emu_suspend <= 1'b0;
			end
		join
		chk("blocked done", ok, 1);
		repeat (40) @(posedge pclk);
		chk("drain count", n_dma - n0, 9);
		chk("drain addr", last_a, 16'h020b);
		chk("drain data", last_w, 16'h2008);
		emu_suspend <= 1'b1;
		for (int i = 0; i < 3; i++) hwr(16'h3000 + 16'(i), 40);
		apb(1'b0, HPRS_OFF_STAT, 0);
		chk("fifo held", rd[11:8], 3);
		apb(1'b1, HPRS_OFF_CTRL, 32'h80);
		apb(1'b0, HPRS_OFF_CTRL, 0);
		chk("reset bit", rd[7], 0);
		apb(1'b1, HPRS_OFF_CTRL, 0);
		repeat (10) @(posedge pclk);
		apb(1'b0, HPRS_OFF_STAT, 0);
		chk("fifo flushed", rd[11:8], 0);
		apb(1'b0, HPRS_OFF_WADDR, 0);
		chk("addr kept", rd, 32'h020c);
		u_hprs_host_model.xfer(1'b1, HPRS_HSEL_WADDR, 16'h0000, 40, hd, ok);
		chk("host waddr", hd, 16'h020c);
		emu_suspend <= 1'b0;
		n0 = n_dma;
		repeat (20) @(posedge pclk);
		chk("nothing left", n_dma - n0, 0);
		idle_req <= 1'b1;
		repeat (5) @(posedge pclk);
		chk("idle ack", idle_ack, 1);
		n0 = n_dma;
		hwr(16'h4000, 10);
		chk("idle host", ok, 0);
		chk("idle dma", n_dma - n0, 0);
		idle_req <= 1'b0;
		repeat (5) @(posedge pclk);
		u_hprs_host_model.xfer(1'b0, HPRS_HSEL_CTRL, 16'h0002, 40, hd, ok);
		apb(1'b1, HPRS_OFF_CTRL, 32'h4);
		@(negedge pclk);
		chk("cpu int", cpu_int, 1);
		chk("host int", host_int, 1);
		// read prefetch fills the read FIFO from the read address
		apb(1'b1, HPRS_OFF_CFG, 32'h1);
		repeat (40) @(posedge pclk);
		u_hprs_host_model.xfer(1'b1, HPRS_HSEL_DATA, 16'h0000, 40, hd, ok);
		chk("prefetch data", hd, 16'hedcb);
		fork
			hwr(16'h5000, 40);
			begin
				@(posedge pclk);
				presetn <= 1'b0;
				repeat (2) @(posedge pclk);
				presetn <= 1'b1;
			end
		join
		chk("reset cycle", ok, 1);
		@(negedge pclk);
		chk("ready after", host_ready, 0);
		chk("cpu int clr", cpu_int, 0);
		chk("host int clr", host_int, 0);
		chk("gpio reset", gpio_oe_n, 8'hff);
		repeat (20) @(posedge pclk);
		apb(1'b0, HPRS_OFF_STAT, 0);
		chk("fifo reset", rd[15:8], 0);
		apb(1'b0, HPRS_OFF_RADDR, 0);
		chk("raddr reset", rd, 0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire

// ---- rtl/hprs_fifo.sv ----
// hprs_fifo: flip-flop FIFO of port data words with synchronous flush.
// assumes push and pop only when not full / not empty.
`timescale 1ns/1ps
`default_nettype none
module hprs_fifo (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flush,
	// write side
	input wire logic push,
	input wire logic [hprs_pkg::HPRS_DW-1:0] push_data,
	// read side
	input wire logic pop,
	output logic [hprs_pkg::HPRS_DW-1:0] pop_data,
	// state
	output logic full,
	output logic empty,
	output logic [hprs_pkg::HPRS_CNT_W-1:0] count
);
	import hprs_pkg::*;

	logic [HPRS_DW-1:0] mem_reg [HPRS_FIFO_DEPTH];
	logic [HPRS_PTR_W-1:0] wr_ptr_reg;
	logic [HPRS_PTR_W-1:0] rd_ptr_reg;
	logic [HPRS_CNT_W-1:0] count_reg;

	assign pop_data = mem_reg[rd_ptr_reg];
	assign count = count_reg;
	assign full = count_reg == HPRS_CNT_W'(HPRS_FIFO_DEPTH);
	assign empty = count_reg == '0;

	always_ff @(posedge pclk) begin
		if (push && !full) begin
			mem_reg[wr_ptr_reg] <= push_data;
		end
	end

	// flush clears pointers and count only; stale words are never read again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push && !full) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop && !empty) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + HPRS_CNT_W'(push && !full) - HPRS_CNT_W'(pop && !empty);
		end
	end

endmodule : hprs_fifo
`default_nettype wire

// ---- rtl/hprs_pkg.sv ----
// hprs_pkg: constants, register map and carrier types for the host port
// reset/suspend control block.
// assumes a 100 MHz core clock and a 32-bit APB register bus.
package hprs_pkg;

	localparam int unsigned HPRS_DW = 16;
	localparam int unsigned HPRS_FIFO_DEPTH = 8;
	localparam int unsigned HPRS_PTR_W = 3;
	localparam int unsigned HPRS_CNT_W = 4;
	localparam int unsigned HPRS_GPIO_W = 8;
	localparam int unsigned HPRS_AW = 8;

	// register byte offsets
	localparam logic [7:0] HPRS_OFF_CTRL = 8'h00;
	localparam logic [7:0] HPRS_OFF_RADDR = 8'h04;
	localparam logic [7:0] HPRS_OFF_WADDR = 8'h08;
	localparam logic [7:0] HPRS_OFF_GPIO = 8'h0c;
	localparam logic [7:0] HPRS_OFF_GPIN = 8'h10;
	localparam logic [7:0] HPRS_OFF_EMU = 8'h14;
	localparam logic [7:0] HPRS_OFF_CFG = 8'h18;
	localparam logic [7:0] HPRS_OFF_STAT = 8'h1c;

	// control register bit positions
	localparam int unsigned HPRS_CTRL_DSPINT = 1;
	localparam int unsigned HPRS_CTRL_HINT = 2;
	localparam int unsigned HPRS_CTRL_READY = 3;
	localparam int unsigned HPRS_CTRL_SWR = 7;
	// power/emulation register bit positions
	localparam int unsigned HPRS_EMU_FREE = 0;
	localparam int unsigned HPRS_EMU_SOFT = 1;
	// gpio register field positions
	localparam int unsigned HPRS_GPIO_EN_LSB = 0;
	localparam int unsigned HPRS_GPIO_DIR_LSB = 8;
	localparam int unsigned HPRS_GPIO_OUT_LSB = 16;

	// host register select codes
	localparam logic [1:0] HPRS_HSEL_CTRL = 2'h0;
	localparam logic [1:0] HPRS_HSEL_DATA = 2'h1;
	localparam logic [1:0] HPRS_HSEL_RADDR = 2'h2;
	localparam logic [1:0] HPRS_HSEL_WADDR = 2'h3;

	// values after reset
	localparam logic [15:0] HPRS_ADDR_RST = 16'h0000;
	localparam logic [23:0] HPRS_GPIO_RST = 24'h000000;
	localparam logic [1:0] HPRS_EMU_RST = 2'h0;

	// reset condition stretch after release of the chip reset
	localparam int unsigned HPRS_CLK_NS = 10;
	localparam int unsigned HPRS_HW_RST_NS = 160;
	localparam int unsigned HPRS_HW_RST_CYC = (HPRS_HW_RST_NS + HPRS_CLK_NS - 1) / HPRS_CLK_NS;
	localparam int unsigned HPRS_SYNC_SETTLE = 2;
	localparam logic [7:0] HPRS_HW_CNT_RST = 8'(HPRS_HW_RST_CYC);
	localparam logic [7:0] HPRS_HW_CNT_CAPT = 8'(HPRS_HW_RST_CYC - HPRS_SYNC_SETTLE);

	typedef struct packed {
		logic strobe_n;
		logic rnw;
		logic [1:0] sel;
		logic [15:0] wdata;
	} hprs_host_pins_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} hprs_dma_req_t;

	typedef enum logic [1:0] {SWR_IDLE, SWR_DRAIN, SWR_HOLD, SWR_FLUSH} hprs_swr_state_t;
	typedef enum logic [1:0] {DMA_IDLE, DMA_WR, DMA_RD} hprs_dma_state_t;

endpackage : hprs_pkg

// ---- rtl/hprs_top.sv ----
// hprs_top: host port reset, emulation-suspend and idle control, with
// host handshake, write/read FIFOs, a DMA mover and an APB register file.
// assumes host pins are asynchronous and DMA/APB/suspend/idle share pclk.
// Notes on behaviour
// (R01) free-run set: suspend ignored entirely
// (R02) free and soft clear: keep running
// (R03) soft suspend: DMA halts after current ops
// (R04) soft suspend: host side keeps working
// (R05) blocked host cycle keeps ready low
// (R06) suspend over: DMA drains and refills FIFOs
// (R07) idle accepted: all activity stops at once
// (R08) host quiesces before idle is requested
// (R09) reset, strobe idle: ready low until done
// (R10) hard reset, active cycle: ready high once
// (R11) hard reset restores register defaults
// (R12) hard reset flushes both FIFOs
// (R13) hard reset clears both interrupts
// (R14) hard reset clears gpio control
// (R15) soft reset: finish DMA, then release host
// (R16) soft reset then clears FIFO pointers
// (R17) soft reset bit reads zero, uncancellable
// (R18) soft reset leaves registers unchanged
// (R19) CPU reaches registers except data word
// (R20) host sees control, data, two addresses
// (R21) reset with active strobe: FIFOs held
// (R22) suspend is a synchronous level input
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module hprs_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [hprs_pkg::HPRS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host pins
	input wire hprs_pkg::hprs_host_pins_t host_pins,
	output logic [hprs_pkg::HPRS_DW-1:0] host_rdata,
	output logic host_ready,
	// dma to memory
	output var hprs_pkg::hprs_dma_req_t dma_out,
	input wire logic dma_ack,
	input wire logic [hprs_pkg::HPRS_DW-1:0] dma_rdata,
	// system
	input wire logic emu_suspend,
	input wire logic idle_req,
	output logic idle_ack,
	output logic cpu_int,
	output logic host_int,
	// gpio pins
	input wire logic [hprs_pkg::HPRS_GPIO_W-1:0] gpio_in,
	output logic [hprs_pkg::HPRS_GPIO_W-1:0] gpio_out,
	output logic [hprs_pkg::HPRS_GPIO_W-1:0] gpio_oe_n
);
	import hprs_pkg::*;

	function automatic logic hit(input logic [HPRS_AW-1:0] a, input logic [7:0] off);
		hit = a == off;
	endfunction : hit

	hprs_host_pins_t pin_s1_reg, pin_s2_reg, cyc_pins_reg;
	logic strobe_d_reg;
	logic [HPRS_GPIO_W-1:0] gpin_s1_reg, gpin_s2_reg;
	logic [7:0] hw_cnt_reg;
	hprs_swr_state_t swr_reg;
	hprs_dma_state_t dma_st_reg;
	hprs_dma_req_t dma_reg;
	logic let_through_reg, ready_q_reg, idle_reg, prefetch_reg;
	logic cpu_int_reg, host_int_reg;
	logic [1:0] emu_reg;
	logic [23:0] gpio_reg;
	logic [HPRS_DW-1:0] raddr_reg, waddr_reg, host_rdata_reg;
	logic [31:0] prdata_reg;

	logic cyc_active, strobe_rise, hw_stretch, rst_cond, soft_halt, dma_go;
	logic host_done, host_wr, host_data, can_complete, fifo_flush;
	logic apb_wr, apb_setup, addr_ok;
	logic wf_full, wf_empty, rf_full, rf_empty, wf_pop, rf_push, wf_push, rf_pop;
	logic [HPRS_DW-1:0] wf_data, rf_data;
	logic [HPRS_CNT_W-1:0] wf_count, rf_count;

	// two-stage synchronisers on every host and gpio pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_reg <= '{strobe_n: 1'b1, rnw: 1'b1, sel: 2'h0, wdata: 16'h0000};
			pin_s2_reg <= '{strobe_n: 1'b1, rnw: 1'b1, sel: 2'h0, wdata: 16'h0000};
			strobe_d_reg <= 1'b1;
			gpin_s1_reg <= '0;
			gpin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= host_pins;
			pin_s2_reg <= pin_s1_reg;
			strobe_d_reg <= pin_s2_reg.strobe_n;
			gpin_s1_reg <= gpio_in;
			gpin_s2_reg <= gpin_s1_reg;
		end
	end

	assign cyc_active = !pin_s2_reg.strobe_n;
	assign strobe_rise = pin_s2_reg.strobe_n && !strobe_d_reg;
	assign hw_stretch = hw_cnt_reg != 8'h00;
	assign rst_cond = hw_stretch || (swr_reg != SWR_IDLE);
	// (R01) (R02) (R22) only free=0, soft=1 halts DMA
	assign soft_halt = emu_suspend && !emu_reg[HPRS_EMU_FREE] && emu_reg[HPRS_EMU_SOFT];
	// (R03) (R06) new DMA starts gated, resumes on its own
	// (R07) no new transfer once idle is requested
	assign dma_go = !soft_halt && !idle_reg && !idle_req && !rst_cond;
	assign host_data = pin_s2_reg.sel == HPRS_HSEL_DATA;
	assign can_complete = !host_data || (pin_s2_reg.rnw ? !rf_empty : !wf_full);

	// (R04) (R05) (R07) (R09) (R10) (R15) ready decision
	always_comb begin
		if (idle_reg) begin
			host_ready = 1'b0;
		end else if (rst_cond) begin
			host_ready = let_through_reg && cyc_active && (swr_reg != SWR_DRAIN);
		end else begin
			host_ready = cyc_active && can_complete;
		end
	end

	// a cycle released by a reset is not committed; its data is lost
	assign host_done = strobe_rise && ready_q_reg && !rst_cond && !idle_reg;
	assign host_wr = host_done && !cyc_pins_reg.rnw;
	assign wf_push = host_wr && cyc_pins_reg.sel == HPRS_HSEL_DATA;
	assign rf_pop = host_done && cyc_pins_reg.rnw && cyc_pins_reg.sel == HPRS_HSEL_DATA;
	// (R12) (R16) (R21) FIFOs flushed while reset and strobe idle, held while a cycle is active
	// soft flush does not wait for a late cycle: it is held off anyway, waiting would lock up
	assign fifo_flush = (hw_stretch && !cyc_active) || (swr_reg == SWR_FLUSH);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q_reg <= 1'b0;
			host_rdata_reg <= 16'h0000;
			cyc_pins_reg <= '{strobe_n: 1'b1, rnw: 1'b1, sel: 2'h0, wdata: 16'h0000};
		end else begin
			ready_q_reg <= host_ready;
			// host may move its lines as strobe rises; commit uses the held copy
			if (cyc_active) begin
				cyc_pins_reg <= pin_s2_reg;
			end
			// (R20) host sees only four registers
			if (cyc_active) begin
				unique case (pin_s2_reg.sel)
					HPRS_HSEL_CTRL: host_rdata_reg <= 16'({host_ready, host_int_reg, cpu_int_reg, 1'b0});
					HPRS_HSEL_DATA: host_rdata_reg <= rf_data;
					HPRS_HSEL_RADDR: host_rdata_reg <= raddr_reg;
					HPRS_HSEL_WADDR: host_rdata_reg <= waddr_reg;
				endcase
			end
		end
	end

	// reset condition stretched past the chip reset release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_cnt_reg <= HPRS_HW_CNT_RST;
		end else if (hw_stretch) begin
			hw_cnt_reg <= hw_cnt_reg - 8'h01;
		end
	end

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;

	// (R15) (R16) (R17) soft reset sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			swr_reg <= SWR_IDLE;
		end else begin
			unique case (swr_reg)
				SWR_IDLE: if (apb_wr && hit(paddr, HPRS_OFF_CTRL) && pwdata[HPRS_CTRL_SWR]) begin
					swr_reg <= SWR_DRAIN;
				end
				SWR_DRAIN: if (dma_st_reg == DMA_IDLE) begin
					swr_reg <= SWR_HOLD;
				end
				SWR_HOLD: if (!(let_through_reg && cyc_active)) begin
					swr_reg <= SWR_FLUSH;
				end
				SWR_FLUSH: swr_reg <= SWR_IDLE;
			endcase
		end
	end

	// (R10) (R15) only a cycle already running at reset may finish
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			let_through_reg <= 1'b0;
		end else if (strobe_rise) begin
			let_through_reg <= 1'b0;
		end else if (hw_cnt_reg == HPRS_HW_CNT_CAPT && hw_stretch) begin
			let_through_reg <= cyc_active;
		end else if (swr_reg == SWR_IDLE && apb_wr && hit(paddr, HPRS_OFF_CTRL) && pwdata[HPRS_CTRL_SWR]) begin
			let_through_reg <= cyc_active;
		end
	end

	// (R07) idle taken only between DMA transfers, then all stops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_reg <= 1'b0;
		end else if (!idle_req) begin
			idle_reg <= 1'b0;
		end else if (dma_st_reg == DMA_IDLE && !dma_reg.req) begin
			idle_reg <= 1'b1;
		end
	end

	// dma mover: write drain first, then read prefetch
	assign wf_pop = dma_st_reg == DMA_WR && dma_ack;
	assign rf_push = dma_st_reg == DMA_RD && dma_ack;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_st_reg <= DMA_IDLE;
			dma_reg <= '0;
		end else begin
			unique case (dma_st_reg)
				DMA_IDLE: if (dma_go && !wf_empty) begin
					dma_st_reg <= DMA_WR;
					dma_reg <= '{req: 1'b1, we: 1'b1, addr: waddr_reg, wdata: wf_data};
				end else if (dma_go && prefetch_reg && !rf_full) begin
					dma_st_reg <= DMA_RD;
					dma_reg <= '{req: 1'b1, we: 1'b0, addr: raddr_reg, wdata: 16'h0000};
				end
				DMA_WR, DMA_RD: if (dma_ack) begin
					dma_st_reg <= DMA_IDLE;
					dma_reg.req <= 1'b0;
				end
				default: dma_st_reg <= DMA_IDLE;
			endcase
		end
	end

	// (R11) (R18) address registers: only chip reset restores them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raddr_reg <= HPRS_ADDR_RST;
			waddr_reg <= HPRS_ADDR_RST;
		end else begin
			if (apb_wr && hit(paddr, HPRS_OFF_RADDR)) begin
				raddr_reg <= pwdata[HPRS_DW-1:0];
			end else if (host_wr && cyc_pins_reg.sel == HPRS_HSEL_RADDR) begin
				raddr_reg <= cyc_pins_reg.wdata;
			end else if (rf_push) begin
				raddr_reg <= raddr_reg + 16'h0001;
			end
			if (apb_wr && hit(paddr, HPRS_OFF_WADDR)) begin
				waddr_reg <= pwdata[HPRS_DW-1:0];
			end else if (host_wr && cyc_pins_reg.sel == HPRS_HSEL_WADDR) begin
				waddr_reg <= cyc_pins_reg.wdata;
			end else if (wf_pop) begin
				waddr_reg <= waddr_reg + 16'h0001;
			end
		end
	end

	// (R13) interrupts; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_int_reg <= 1'b0;
			host_int_reg <= 1'b0;
		end else begin
			if (host_wr && cyc_pins_reg.sel == HPRS_HSEL_CTRL && cyc_pins_reg.wdata[HPRS_CTRL_DSPINT]) begin
				cpu_int_reg <= 1'b1;
			end else if (apb_wr && hit(paddr, HPRS_OFF_CTRL) && pwdata[HPRS_CTRL_DSPINT]) begin
				cpu_int_reg <= 1'b0;
			end
			if (apb_wr && hit(paddr, HPRS_OFF_CTRL) && pwdata[HPRS_CTRL_HINT]) begin
				host_int_reg <= 1'b1;
			end else if (host_wr && cyc_pins_reg.sel == HPRS_HSEL_CTRL && cyc_pins_reg.wdata[HPRS_CTRL_HINT]) begin
				host_int_reg <= 1'b0;
			end
		end
	end

	// (R11) (R14) config, emulation and gpio registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			emu_reg <= HPRS_EMU_RST;
			prefetch_reg <= 1'b0;
			gpio_reg <= HPRS_GPIO_RST;
		end else if (apb_wr) begin
			if (hit(paddr, HPRS_OFF_EMU)) begin
				emu_reg <= pwdata[1:0];
			end
			if (hit(paddr, HPRS_OFF_CFG)) begin
				prefetch_reg <= pwdata[0];
			end
			if (hit(paddr, HPRS_OFF_GPIO)) begin
				gpio_reg <= pwdata[23:0];
			end
		end
	end

	// (R19) CPU map; data word deliberately absent
	assign addr_ok = hit(paddr, HPRS_OFF_CTRL) || hit(paddr, HPRS_OFF_RADDR) || hit(paddr, HPRS_OFF_WADDR)
		|| hit(paddr, HPRS_OFF_GPIO) || hit(paddr, HPRS_OFF_GPIN) || hit(paddr, HPRS_OFF_EMU)
		|| hit(paddr, HPRS_OFF_CFG) || hit(paddr, HPRS_OFF_STAT);

	// read data sampled in the setup cycle so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (apb_setup) begin
			prdata_reg <= 32'h00000000;
			// (R17) soft reset bit always reads zero
			if (hit(paddr, HPRS_OFF_CTRL)) begin
				prdata_reg[HPRS_CTRL_READY] <= host_ready;
				prdata_reg[HPRS_CTRL_HINT] <= host_int_reg;
				prdata_reg[HPRS_CTRL_DSPINT] <= cpu_int_reg;
			end
			if (hit(paddr, HPRS_OFF_RADDR)) begin
				prdata_reg[15:0] <= raddr_reg;
			end
			if (hit(paddr, HPRS_OFF_WADDR)) begin
				prdata_reg[15:0] <= waddr_reg;
			end
			if (hit(paddr, HPRS_OFF_GPIO)) begin
				prdata_reg[23:0] <= gpio_reg;
			end
			if (hit(paddr, HPRS_OFF_GPIN)) begin
				prdata_reg[HPRS_GPIO_W-1:0] <= gpin_s2_reg;
			end
			if (hit(paddr, HPRS_OFF_EMU)) begin
				prdata_reg[1:0] <= emu_reg;
			end
			if (hit(paddr, HPRS_OFF_CFG)) begin
				prdata_reg[0] <= prefetch_reg;
			end
			if (hit(paddr, HPRS_OFF_STAT)) begin
				prdata_reg[15:0] <= {rf_count, wf_count, 3'h0, dma_reg.req, idle_reg, soft_halt,
					swr_reg != SWR_IDLE, hw_stretch};
			end
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign host_rdata = host_rdata_reg;
	assign dma_out = dma_reg;
	assign idle_ack = idle_reg;
	assign cpu_int = cpu_int_reg;
	assign host_int = host_int_reg;
	assign gpio_out = gpio_reg[HPRS_GPIO_OUT_LSB +: HPRS_GPIO_W];
	assign gpio_oe_n = ~(gpio_reg[HPRS_GPIO_EN_LSB +: HPRS_GPIO_W] & gpio_reg[HPRS_GPIO_DIR_LSB +: HPRS_GPIO_W]);

	hprs_fifo u_wfifo (
		.pclk(pclk),
		.presetn(presetn),
		.flush(fifo_flush),
		.push(wf_push),
		.push_data(cyc_pins_reg.wdata),
		.pop(wf_pop),
		.pop_data(wf_data),
		.full(wf_full),
		.empty(wf_empty),
		.count(wf_count)
	);

	hprs_fifo u_rfifo (
		.pclk(pclk),
		.presetn(presetn),
		.flush(fifo_flush),
		.push(rf_push),
		.push_data(dma_rdata),
		.pop(rf_pop),
		.pop_data(rf_data),
		.full(rf_full),
		.empty(rf_empty),
		.count(rf_count)
	);

	a_idle_ready_low: assert property (@(posedge pclk) disable iff (!presetn) idle_reg |-> !host_ready) // (R07)
		else $error("ready high while idle");
	a_idle_no_dma: assert property (@(posedge pclk) disable iff (!presetn) // (R07)
		idle_reg && !dma_out.req |=> !dma_out.req)
		else $error("dma started while idle");
	a_halt_no_start: assert property (@(posedge pclk) disable iff (!presetn) // (R03)
		soft_halt && !dma_out.req |=> !dma_out.req)
		else $error("dma started in soft suspend");
	a_free_no_halt: assert property (@(posedge pclk) disable iff (!presetn) // (R01)
		emu_reg[HPRS_EMU_FREE] || !emu_reg[HPRS_EMU_SOFT] |-> !soft_halt)
		else $error("suspend halted dma with free or soft clear");
	a_swr_reads_zero: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
		psel && penable && !pwrite && hit(paddr, HPRS_OFF_CTRL) |-> !prdata[HPRS_CTRL_SWR])
		else $error("soft reset bit read nonzero");
	a_swr_no_cancel: assert property (@(posedge pclk) disable iff (!presetn) // (R17)
		swr_reg == SWR_DRAIN && apb_wr |=> swr_reg != SWR_IDLE)
		else $error("soft reset cancelled");
	a_drain_ready_low: assert property (@(posedge pclk) disable iff (!presetn) // (R15)
		swr_reg == SWR_DRAIN |-> !host_ready)
		else $error("ready before dma drained");
	a_rst_ready_drop: assert property (@(posedge pclk) disable iff (!presetn) // (R10)
		rst_cond && strobe_rise |-> !host_ready ##1 (!host_ready || !rst_cond))
		else $error("ready rose again after released cycle");
	a_flush_empties: assert property (@(posedge pclk) disable iff (!presetn) // (R16)
		swr_reg == SWR_FLUSH && !cyc_active |=> wf_empty && rf_empty)
		else $error("fifos not empty after soft reset");
	a_swr_keeps_addr: assert property (@(posedge pclk) disable iff (!presetn) // (R18)
		swr_reg == SWR_FLUSH && !apb_wr |=> $stable(raddr_reg) && $stable(waddr_reg))
		else $error("soft reset changed address registers");

endmodule : hprs_top
`default_nettype wire
